// ---- spi_slave_host_port_defs.vh ----
/*
  Constants for the serial host port: mode encoding, counter and reset values and
  command byte layout.
  Assumes inclusion by the single design file of the port.
*/
`ifndef SPI_SLAVE_HOST_PORT_DEFS_VH
`define SPI_SLAVE_HOST_PORT_DEFS_VH

`define MODE_0          2'h0
`define MODE_1          2'h1
`define MODE_2          2'h2
`define MODE_3          2'h3
`define MODE_CPOL_BIT   1
`define MODE_CPHA_BIT   0
`define CMD_WRITE_BIT   7
`define CMD_DMA_BIT     6
`define CMD_DATA_BIT    5
`define BIT_CNT_RESET   4'h0
`define STRAP_TAKE      2'h2
`define STRAP_LAST      2'h3
`define TX_RESET        8'h00

`endif

// ---- spi_slave_host_port.v ----
/*
  Serial slave host port: samples the host clock, select and data lines
  with the system clock, shifts bytes in and out in any of four modes, and
  decodes the first byte of each frame as a command.
  Assumes the host clock runs well below a quarter of sys_clk, and that
  the register, DMA and payload logic behind it answers with tx_byte.
*/
`timescale 1ns/1ns
`include "spi_slave_host_port_defs.vh"

// Notes on behaviour
// R01 - The port is a full-duplex slave timed by the host's serial clock, which it samples with sys_clk.
// R02 - Receive pin is master-out/slave-in, transmit pin is master-in/slave-out.
// R03 - The port works from reset only if the select strap is high when it is caught once after reset.
// R04 - Chip select is active low and a high level means not selected.
// R05 - While not selected the port leaves shared bus traffic alone.
// R06 - While not selected the data output is released to high impedance.
// R07 - Four modes are served, numbered by clock polarity and phase.
// R08 - A command byte lets the host read or write any internal register.
// R09 - The same command byte lets the host start an internal DMA transfer.
// R10 - The port carries both control accesses and network payload data.
// R11 - Phase 0 samples on the leading edge and phase 1 on the trailing one.
module spi_slave_host_port #(
  parameter WIDTH = 8
) (
  input  wire             sys_clk,
  input  wire             arst_n,
  input  wire             cfg_strap,
  input  wire [1:0]       spi_mode,
  input  wire             sck,
  input  wire             chip_select_low,
  input  wire             mosi,
  output reg              miso_out,
  output reg              miso_oe,
  input  wire [WIDTH-1:0] tx_byte,
  output reg              tx_take,
  output reg  [WIDTH-1:0] rx_byte,
  output reg              rx_valid,
  output reg              rx_is_cmd,
  output reg              cmd_write,
  output reg              cmd_read,
  output reg              cmd_dma,
  output reg              cmd_data,
  output reg              frame_end,
  output reg              spi_enabled
);
  reg [2:0]       sck_s;
  reg [2:0]       cs_s;
  reg [1:0]       mosi_s;
  reg [1:0]       strap_s;
  reg [1:0]       strap_cnt;
  reg [3:0]       bit_cnt;
  reg [WIDTH-1:0] shift_in;
  reg [WIDTH-1:0] shift_out;
  reg             first_byte;
  reg             cpol;
  reg             cpha;
  wire            sel;
  wire            lead;
  wire            trail;
  wire            samp;
  wire            shft;
  wire [WIDTH-1:0] next_in;
  wire            byte_done;

  // R04 active low select, gated by the strap
  assign sel   = ~cs_s[1] & spi_enabled;
  // R07 polarity decides which raw edge leads
  assign lead  = cpol ? (sck_s[2] & ~sck_s[1]) : (~sck_s[2] & sck_s[1]);
  assign trail = cpol ? (~sck_s[2] & sck_s[1]) : (sck_s[2] & ~sck_s[1]);
  // R11 phase picks sample edge
  assign samp  = cpha ? trail : lead;
  assign shft  = cpha ? lead : trail;
  // R02 receive on the master-out line
  assign next_in = {shift_in[WIDTH-2:0], mosi_s[1]};
  // Last sample edge of a byte
  assign byte_done = sel & samp & (bit_cnt == WIDTH - 1);

  // Synchronisers; the second stage feeds logic, and the third stage of sck and select feeds edge detection
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_s  <= 3'h0;
      cs_s   <= 3'h7;
      mosi_s <= 2'h0;
    end else begin
      sck_s  <= {sck_s[1:0], sck};
      cs_s   <= {cs_s[1:0], chip_select_low};
      mosi_s <= {mosi_s[0], mosi};
    end
  end

  // R03 strap passes two flip-flops, then is caught once
  // Later strap changes are ignored so a noisy pin cannot drop the port
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_s     <= 2'h0;
      strap_cnt   <= 2'h0;
      spi_enabled <= 1'b0;
    end else begin
      strap_s <= {strap_s[0], cfg_strap};
      if (strap_cnt != `STRAP_LAST) begin
        strap_cnt <= strap_cnt + 2'h1;
      end
      if (strap_cnt == `STRAP_TAKE) begin
        spi_enabled <= strap_s[1];
      end
    end
  end

  // Receive path and bit counting
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt    <= `BIT_CNT_RESET;
      shift_in   <= `TX_RESET;
      first_byte <= 1'b1;
      cpol       <= 1'b0;
      cpha       <= 1'b0;
      rx_byte    <= `TX_RESET;
      rx_valid   <= 1'b0;
      rx_is_cmd  <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (!sel) begin
        // R05 idle while deselected; mode latched between frames
        // A partial byte is dropped when the frame is cut
        bit_cnt    <= `BIT_CNT_RESET;
        first_byte <= 1'b1;
        cpol       <= spi_mode[`MODE_CPOL_BIT];
        cpha       <= spi_mode[`MODE_CPHA_BIT];
      end else if (samp) begin
        shift_in <= next_in;
        if (byte_done) begin
          bit_cnt    <= `BIT_CNT_RESET;
          rx_byte    <= next_in;
          rx_valid   <= 1'b1;
          rx_is_cmd  <= first_byte;
          first_byte <= 1'b0;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
    end
  end

  // Transmit path
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_out <= `TX_RESET;
      miso_out  <= 1'b0;
      miso_oe   <= 1'b0;
      tx_take   <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      if (!sel) begin
        shift_out <= tx_byte;
        // R06 release the output
        miso_oe   <= 1'b0;
        miso_out  <= 1'b0;
      end else begin
        // R01 drive while selected, full duplex
        miso_oe <= 1'b1;
        // R11 phase 0 shows first bit before the leading edge
        if (!cpha && bit_cnt == `BIT_CNT_RESET && !samp) begin
          miso_out <= shift_out[WIDTH-1];
        end
        if (shft && cpha) begin
          // R02 transmit on the master-in line
          miso_out  <= shift_out[WIDTH-1];
          shift_out <= {shift_out[WIDTH-2:0], 1'b0};
        end else if (shft && bit_cnt != `BIT_CNT_RESET) begin
          // Phase 0 already shows the top bit, so the next one follows
          miso_out  <= shift_out[WIDTH-2];
          shift_out <= {shift_out[WIDTH-2:0], 1'b0};
        end
        if (byte_done) begin
          tx_take   <= 1'b1;
          shift_out <= tx_byte;
        end
      end
    end
  end

  // Command decode of the first byte; flags stand until the next frame
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_write <= 1'b0;
      cmd_read  <= 1'b0;
      cmd_dma   <= 1'b0;
      cmd_data  <= 1'b0;
    end else if (byte_done && first_byte) begin
      // R08 register read or write
      cmd_write <= next_in[`CMD_WRITE_BIT];
      cmd_read  <= ~next_in[`CMD_WRITE_BIT];
      // R09 DMA start
      cmd_dma   <= next_in[`CMD_DMA_BIT];
      // R10 payload or control
      cmd_data  <= next_in[`CMD_DATA_BIT];
    end
  end

  // R04 select rise past the synchroniser closes the frame
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_end <= 1'b0;
    end else begin
      frame_end <= !cs_s[2] && cs_s[1] && spi_enabled;
    end
  end
endmodule

// ---- spi_slave_host_port_properties.sv ----
/* Checker on the serial host port outputs.
   Assumes binding to every instance of the port. */
`timescale 1ns/1ns
module spi_slave_host_port_properties (
  input wire sys_clk,
  input wire arst_n,
  input wire chip_select_low,
  input wire miso_oe,
  input wire rx_valid,
  input wire rx_is_cmd,
  input wire cmd_write,
  input wire cmd_read,
  input wire frame_end,
  input wire spi_enabled
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_off; !spi_enabled |-> !miso_oe && !rx_valid; endproperty
  a_off: assert property (p_off) else $error("port active");
  property p_once; $past(spi_enabled) |-> spi_enabled; endproperty
  a_once: assert property (p_once) else $error("strap lost");
  property p_hiz; chip_select_low [*5] |-> !miso_oe; endproperty
  a_hiz: assert property (p_hiz) else $error("miso driven");
  property p_quiet; chip_select_low [*5] |-> !rx_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("rx idle");
  property p_oe; $rose(miso_oe) |-> !chip_select_low; endproperty
  a_oe: assert property (p_oe) else $error("oe unselected");
  property p_fe; frame_end |-> chip_select_low; endproperty
  a_fe: assert property (p_fe) else $error("frame end early");
  property p_pulse; rx_valid |=> !rx_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("rx pulse");
  property p_rw; rx_valid && rx_is_cmd |=> cmd_write ^ cmd_read; endproperty
  a_rw: assert property (p_rw) else $error("rw decode");
  property p_hold; $changed(cmd_write) |-> rx_is_cmd; endproperty
  a_hold: assert property (p_hold) else $error("cmd moved");
endmodule
bind spi_slave_host_port spi_slave_host_port_properties p_i (.*);

// ---- spi_host_model.sv ----
/* Host master model driving one frame of two bytes.
   Assumes the bench calls frame while the clock stands. */
`timescale 1ns/1ns
module spi_host_model (
  output reg sck,
  output reg chip_select_low,
  output reg mosi,
  input wire miso
);
  integer i;
  initial {sck, chip_select_low, mosi} = 3'h2;
  task frame(input [1:0] md, input [15:0] d, output [15:0] got);
    begin
      // idle level is polarity, select low
      sck = md[1];
      #100 chip_select_low = 0;
      #200;
      // phase picks change and sample edge
      for (i = 15; i >= 0; i = i - 1) begin
        if (!md[0]) mosi = d[i];
        #80 sck = ~sck;
        if (md[0]) mosi = d[i]; else got[i] = miso;
        #80 sck = ~sck;
        if (md[0]) got[i] = miso;
        // Pause lets the next byte load before its first bit
        if (i == 8) #400;
      end
      #200 chip_select_low = 1;
      mosi = ~mosi;
      #300;
    end
  endtask
endmodule

// ---- spi_slave_host_port_tb.sv ----
/* Bench for the serial host port with a host model.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/1ns
module spi_slave_host_port_tb;
  reg sys_clk = 0, arst_n = 0, cfg_strap = 0;
  reg [1:0] spi_mode = 0;
  reg [7:0] tx_byte = 0, r = 8'h0C;
  reg [15:0] got, d;
  reg [8:0] q[$];
  integer n_fail = 0, samples_checked = 0, md;
  integer n_take = 0, n_end = 0;
  wire sck, chip_select_low, mosi, miso_out, miso_oe, tx_take, rx_valid;
  wire rx_is_cmd, cmd_write, cmd_read, cmd_dma, cmd_data, frame_end;
  wire spi_enabled;
  wire [7:0] rx_byte;
  wire miso = miso_oe ? miso_out : ~miso_out;
  spi_slave_host_port spi_slave_host_port_i (.*);
  spi_host_model spi_host_model_i (.*);
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (rx_valid) q.push_back({rx_is_cmd, rx_byte});
  always @(posedge sys_clk) begin
    if (tx_take) n_take++;
    if (frame_end) n_end++;
  end
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input string n, input [17:0] e, input [17:0] g);
    begin
      samples_checked++;
      if (e !== g) begin
        n_fail++;
        $display("ERROR %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task conclude;
    begin
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task run(input s);
    begin
      @(posedge sys_clk) #2 arst_n = 0;
      cfg_strap = s;
      repeat (10) @(posedge sys_clk);
      #2 arst_n = 1;
      repeat (4) @(posedge sys_clk);
      chk("enabled", s, spi_enabled);
      n_take = 0;
      n_end = 0;
    end
  endtask
  initial begin
    run(0);
    spi_host_model_i.frame(2'h0, 16'hA5C3, got);
    chk("rx count", 0, q.size());
    chk("take count", 0, n_take);
    chk("oe off", 0, miso_oe);
    $display("strap low done");
    run(1);
    for (md = 0; md < 4; md++) begin
      @(posedge sys_clk) #2 spi_mode = md;
      r = lfsr(r);
      tx_byte = r;
      r = lfsr(r);
      d = {r, tx_byte ^ 8'h5A};
      q.delete();
      n_take = 0;
      n_end = 0;
      spi_host_model_i.frame(md[1:0], d, got);
      chk("take count", 2, n_take);
      chk("frame end", 1, n_end);
      chk("oe after", 0, miso_oe);
      chk("miso", {2{tx_byte}}, got);
      chk("rx", {1'b1, d[15:8], 1'b0, d[7:0]}, {q[0], q[1]});
      chk("cmd", {d[15], ~d[15], d[14:13]}, {cmd_write, cmd_read, cmd_dma, cmd_data});
      $display("mode %0d done", md);
    end
    conclude;
  end
  initial begin
    #100000;
    n_fail++;
    conclude;
  end
endmodule
